//--- fhbp_pkg.sv
// shared constants for the floppy host bus port
package fhbp_pkg;
    localparam int FHBP_ADDR_W = 3;
    localparam int FHBP_DATA_W = 8;
    // address that a dma acknowledge stands in for
    localparam logic [2:0] FHBP_ADDR_DATA = 3'h5;
    // address of the digital output register
    localparam logic [2:0] FHBP_ADDR_DOR = 3'h2;
    // address of the main status register
    localparam logic [2:0] FHBP_ADDR_MSR = 3'h4;
    // bit of the digital output register that gates dma and interrupt
    localparam int FHBP_DOR_GATE_BIT = 3;
    localparam logic [7:0] FHBP_DOR_RESET = 8'h00;
    localparam logic [7:0] FHBP_DATA_RESET = 8'h00;
    // address held for a strobe after reset, before any access
    localparam logic [2:0] FHBP_ADDR_RESET = 3'h0;
    // timing clock
    localparam int FHBP_CLK_MHZ = 16;
    localparam int FHBP_CLK_PERIOD_NS = 1000 / FHBP_CLK_MHZ;
endpackage

//--- fhbp_edge.sv
// strobe edge detector for one active-low host strobe
`timescale 1ns/1ps
module fhbp_edge (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic strobe_n,
    output logic rise
);
    logic prev_q;

    // remember last level; trailing edge is where data is latched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= strobe_n;
        end
    end

    assign rise = strobe_n && !prev_q;
endmodule

//--- fhbp_port.sv
// host bus port of the floppy subsystem controller
`timescale 1ns/1ps
module fhbp_port #(
    parameter int DATA_W = fhbp_pkg::FHBP_DATA_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic host_compat_select,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [fhbp_pkg::FHBP_ADDR_W-1:0] register_address,
    input wire logic [DATA_W-1:0] host_data_bus_in,
    output logic [DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe,
    input wire logic transfer_acknowledge_n,
    input wire logic transfer_final_count,
    output logic dma_request_out,
    output logic dma_request_oe,
    output logic interrupt_out,
    output logic interrupt_oe,
    input wire logic core_dma_request,
    input wire logic core_command_done,
    input wire logic core_byte_request,
    input wire logic core_dma_mode,
    input wire logic [DATA_W-1:0] core_status,
    input wire logic [DATA_W-1:0] core_read_data,
    output logic [DATA_W-1:0] core_write_data,
    output logic core_write_strobe,
    output logic core_read_strobe,
    output logic core_final_count,
    output logic [DATA_W-1:0] dor_value
);
    import fhbp_pkg::*;

    logic rst_meta_q;
    logic rst_n_q;
    logic mode_adv_q;
    logic [DATA_W-1:0] dor_q;
    logic [DATA_W-1:0] wdata_q;
    logic wstb_q;
    logic rstb_q;
    logic tc_q;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q;
    logic gate;
    logic ack_ok;
    logic sel;
    logic [FHBP_ADDR_W-1:0] addr_eff;
    logic wr_rise;
    logic rd_rise;
    logic tc_active;
    logic [FHBP_ADDR_W-1:0] addr_q;

    // one clock times everything
    // reset release through two flops; async assert only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // mode capture
    // pin is static, so sampling every cycle only tracks a strap change
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_adv_q <= 1'b0;
        end else begin
            mode_adv_q <= host_compat_select;
        end
    end

    assign gate = mode_adv_q || dor_q[FHBP_DOR_GATE_BIT];
    assign ack_ok = !transfer_acknowledge_n && gate;
    // acknowledge stands in for chip select plus data address
    assign sel = !chip_select_n || ack_ok;
    assign addr_eff = ack_ok ? FHBP_ADDR_DATA : register_address;

    fhbp_edge u_wr_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .strobe_n(write_n || !sel),
        .rise(wr_rise)
    );

    fhbp_edge u_rd_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .strobe_n(read_n || !sel),
        .rise(rd_rise)
    );

    // address of the strobe in progress, kept for its trailing edge
    // an acknowledge may drop together with its strobe, so decoding at the edge would lose it
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            addr_q <= FHBP_ADDR_RESET;
        end else if (sel && !(write_n && read_n)) begin
            addr_q <= addr_eff;
        end
    end

    // write latching at strobe end; dor kept here, rest passed on
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dor_q <= FHBP_DOR_RESET;
            wdata_q <= FHBP_DATA_RESET;
            wstb_q <= 1'b0;
        end else begin
            wstb_q <= wr_rise && (addr_q != FHBP_ADDR_DOR);
            if (!write_n && sel) begin
                wdata_q <= host_data_bus_in;
            end
            if (wr_rise && addr_q == FHBP_ADDR_DOR) begin
                dor_q <= wdata_q;
            end
        end
    end

    // read data capture, registered so the bus comes from flops
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= FHBP_DATA_RESET;
            rstb_q <= 1'b0;
        end else begin
            rstb_q <= rd_rise && (addr_q == FHBP_ADDR_DATA);
            unique case (addr_eff)
                FHBP_ADDR_MSR: rdata_q <= core_status;
                FHBP_ADDR_DOR: rdata_q <= dor_q;
                FHBP_ADDR_DATA: rdata_q <= core_read_data;
                default: rdata_q <= FHBP_DATA_RESET;
            endcase
        end
    end

    // drive the bus only during a selected read
    assign host_data_bus_out = rdata_q;
    assign host_data_bus_oe = sel && !read_n;

    // polarity per mode; qualified by honoured acknowledge
    assign tc_active = mode_adv_q ? !transfer_final_count : transfer_final_count;
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tc_q <= 1'b0;
        end else begin
            tc_q <= tc_active && ack_ok;
        end
    end

    // interrupt source: completion, or per-byte request without dma
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= core_command_done || (core_byte_request && !core_dma_mode);
        end
    end

    assign dma_request_out = core_dma_request;
    assign dma_request_oe = gate;
    // legacy active-high tristate; advanced open drain pulls low
    assign interrupt_out = mode_adv_q ? 1'b0 : irq_q;
    assign interrupt_oe = mode_adv_q ? irq_q : gate;

    assign core_write_data = wdata_q;
    assign core_write_strobe = wstb_q;
    assign core_read_strobe = rstb_q;
    assign core_final_count = tc_q;
    assign dor_value = dor_q;

    a_bus_release: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        (read_n || !sel) |-> !host_data_bus_oe) else $error("bus driven outside read");
    // dma pin released in legacy ungated
    a_dma_gate: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        (!mode_adv_q && !dor_q[FHBP_DOR_GATE_BIT]) |-> !dma_request_oe) else $error("dma not released");
    a_adv_gate: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        mode_adv_q |-> dma_request_oe) else $error("gate not forced");
    // completion raises interrupt one cycle later
    a_irq_done: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        core_command_done |=> irq_q) else $error("completion irq missing");
    // legacy interrupt driven high only when gated
    a_irq_legacy: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        (!mode_adv_q && interrupt_oe) |-> dor_q[FHBP_DOR_GATE_BIT] && interrupt_out == irq_q)
        else $error("legacy irq wrong");
    a_irq_od: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        (mode_adv_q && interrupt_oe) |-> !interrupt_out) else $error("open drain drove high");
    a_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        (chip_select_n && !ack_ok) [*2] |=> !wstb_q) else $error("unselected write taken");
    a_tc_qual: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        $past(transfer_acknowledge_n) |-> !tc_q) else $error("final count without ack");
    a_tc_low: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        (mode_adv_q && ack_ok && !transfer_final_count) |=> tc_q) else $error("low final count lost");
    // honoured acknowledge reads the data address
    a_ack_addr: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        (ack_ok && !read_n) |=> addr_q == FHBP_ADDR_DATA) else $error("ack read not at data address");
endmodule

//--- fhbp_dma_model.sv
// dma channel partner model for the floppy host bus port
`timescale 1ns/1ps
module fhbp_dma_model (
    input wire logic clk_sys,
    input wire logic enable,
    input wire logic advanced,
    input wire logic request,
    output logic ack_n,
    output logic read_n,
    output logic final_count,
    output int count
);
    initial begin
        ack_n = 1'b1;
        read_n = 1'b1;
        final_count = 1'b0;
        count = 0;
    end
    // one byte per grant, terminal count shown on every byte to stress it
    // final count asserted
    always begin
        @(negedge clk_sys);
        if (enable && request === 1'b1) begin
            ack_n <= 0;
            read_n <= 0;
            final_count <= !advanced;
            repeat (2) @(negedge clk_sys);
            ack_n <= 1;
            read_n <= 1;
            final_count <= advanced;
            count <= count + 1;
        end
    end
endmodule

//--- floppy_host_bus_port_bench.sv
// self-checking testbench for the floppy host bus port
`timescale 1ns/1ps
module floppy_host_bus_port_bench;
    import fhbp_pkg::*;
    logic clk_sys = 0, reset_n = 0, mode = 0, cs_n = 1, h_rd_n = 1, wr_n = 1, b_ack_n = 1, b_tc = 0;
    logic dma_en = 0, drq = 0, done = 0, byte_rq = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] din = 8'h00, st = 8'h3c, rdat = 8'ha5;
    logic [7:0] dout, wdat, dor;
    logic doe, rq_o, rq_oe, irq_o, irq_oe, wstb, rstb, fc, m_ack_n, m_rd_n, m_tc;
    int err_total = 0, num_checks = 0, cnt;
    int n_wstb = 0, n_rstb = 0;
    // core strobes counted mid-cycle, where the one-cycle pulses are settled
    always @(negedge clk_sys) begin
        if (wstb === 1'b1) n_wstb++;
        if (rstb === 1'b1) n_rstb++;
    end
    // resolved lines: request pulled down, interrupt pulled up in advanced mode
    // external pull-up
    wire logic irq_w = irq_oe ? irq_o : mode;
    wire logic rq_w = rq_oe ? rq_o : 1'b0;
    wire logic [7:0] bus = doe ? dout : din;
    always #5 clk_sys = ~clk_sys;
    fhbp_port i_fhbp_port (.clk_sys(clk_sys), .reset_n(reset_n), .host_compat_select(mode),
        .chip_select_n(cs_n), .read_n(h_rd_n & m_rd_n), .write_n(wr_n), .register_address(addr),
        .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe(doe),
        .transfer_acknowledge_n(b_ack_n & m_ack_n), .transfer_final_count(dma_en ? m_tc : b_tc),
        .dma_request_out(rq_o), .dma_request_oe(rq_oe), .interrupt_out(irq_o), .interrupt_oe(irq_oe),
        .core_dma_request(drq), .core_command_done(done), .core_byte_request(byte_rq),
        .core_dma_mode(dma_en), .core_status(st), .core_read_data(rdat), .core_write_data(wdat),
        .core_write_strobe(wstb), .core_read_strobe(rstb), .core_final_count(fc), .dor_value(dor));
    fhbp_dma_model i_fhbp_dma_model (.clk_sys(clk_sys), .enable(dma_en), .advanced(mode),
        .request(rq_w), .ack_n(m_ack_n), .read_n(m_rd_n), .final_count(m_tc), .count(cnt));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d, input logic sel_n);
        cs_n = sel_n; addr = a; din = d; wr_n = 0; cyc(1);
        wr_n = 1; cyc(1); cs_n = 1; cyc(3);
    endtask
    // bus driven only while the read strobe is held
    task rd(input logic [2:0] a, input logic [7:0] e);
        cs_n = 0; addr = a; h_rd_n = 0; cyc(2);
        chk(8'(doe), 8'h01); chk(dout, e);
        h_rd_n = 1; cs_n = 1; cyc(1);
        chk(8'(doe), 8'h00);
    endtask
    task results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task t_regs();
        chk(8'(doe | rq_oe | irq_oe), 8'h00); chk(dor, FHBP_DOR_RESET);
        wr(FHBP_ADDR_DOR, 8'h08, 1); chk(dor, 8'h00);
        wr(FHBP_ADDR_DOR, 8'h08, 0); chk(dor, 8'h08); chk(8'(rq_oe), 8'h01);
        wr(FHBP_ADDR_DATA, 8'h5a, 0); chk(wdat, 8'h5a);
        chk(8'(n_wstb), 8'h01);
        rd(FHBP_ADDR_MSR, st);
        rd(FHBP_ADDR_DATA, rdat);
        rd(3'h0, 8'h00);
        chk(8'(n_rstb), 8'h01);
        $display("regs done");
    endtask
    // gate cleared in legacy mode: acknowledge, count and interrupt all held off
    task t_gate();
        wr(FHBP_ADDR_DOR, 8'h00, 0); chk(8'(rq_oe), 8'h00);
        b_ack_n = 0; b_tc = 1; h_rd_n = 0; done = 1; cyc(2);
        chk(8'(doe), 8'h00); chk(8'(fc), 8'h00); chk(8'(irq_oe), 8'h00);
        b_ack_n = 1; b_tc = 0; h_rd_n = 1; cyc(1);
        wr(FHBP_ADDR_DOR, 8'h08, 0); chk(8'(irq_oe & irq_o), 8'h01);
        done = 0; cyc(1);
        $display("gate done");
    endtask
    task t_dma(input logic adv);
        int i, c0;
        mode = adv; c0 = cnt;
        if (adv) wr(FHBP_ADDR_DOR, 8'h00, 0);
        chk(8'(rq_oe), 8'h01);
        drq = 1; dma_en = 1;
        for (i = 0; i < 20 && m_ack_n !== 1'b0; i++) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(8'(rq_oe & rq_o), 8'h01); chk(8'(doe), 8'h01); chk(dout, rdat);
        chk(8'(fc), 8'h01);
        drq = 0; dma_en = 0; cyc(3);
        chk(8'(cnt - c0), 8'h01);
        byte_rq = 1; cyc(2);
        chk(8'(irq_oe), 8'h01); chk(8'(irq_w), 8'(!adv));
        chk(8'(n_rstb), 8'h02 + 8'(adv));
        chk(8'(n_wstb), 8'h01);
        byte_rq = 0; mode = 0; cyc(2);
        $display("dma done");
    endtask
    initial begin
        cyc(16);
        reset_n = 1;
        cyc(4);
        t_regs();
        t_gate();
        t_dma(0);
        t_dma(1);
        results();
    end
    // watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule
